// File: common/dcmb_pkg.sv
// Shared constants and carrier types for the dual port mailbox pair.
// Operation
// [RULE1] Two 36-bit mail registers, A-to-B and B-to-A, apart from FIFO.
// [RULE2] Port-A mail write stores port-A data into the A-to-B register.
// [RULE3] Port-B mail write stores port-B data into the B-to-A register.
// [RULE4] An accepted mail write drives that register's full flag low.
// [RULE5] While a full flag is low, writes to that register are ignored.
// [RULE6] Enabled port-B outputs show FIFO word, or A-to-B mail when selected.
// [RULE7] Enabled port-A outputs always show the B-to-A mail register.
// [RULE8] Port-B mail read returns the A-to-B full flag high.
// [RULE9] Port-A mail read returns the B-to-A full flag high.
// [RULE10] Reads leave mail intact; only accepted writes change it.
// [RULE11] Host selects access by chip select, direction and mail select.
// [RULE12] Cascaded systems hold both mail selects low.
// [RULE13] Access counts only with chip select low and port enable high.
package dcmb_pkg;

    // Width of one mail word.
    localparam int unsigned DCMB_DATA_W = 36;

    // Reset values of the mail words and their active-low full flags.
    localparam logic [35:0] DCMB_MAIL_RST   = 36'h0_0000_0000;
    localparam logic        DCMB_FULL_N_RST = 1'h1;

    // Direction level that means write on port A and read on port B.
    localparam logic        DCMB_A_DIR_WRITE = 1'h1;
    localparam logic        DCMB_B_DIR_READ  = 1'h1;

    // Control pins of one port, bundled as they arrive.
    typedef struct packed {
        logic chip_select_n;
        logic direction;
        logic enable;
        logic mail_select;
    } dcmb_port_ctl_s;

    // Decoded access kinds of one port.
    typedef struct packed {
        logic mail_write;
        logic mail_read;
        logic out_active;
    } dcmb_port_dec_s;

endpackage

// File: hw/dcmb_mailbox.sv
// Mailbox pair passing 36-bit words between port A and port B.
`timescale 1ns/1ps
module dcmb_mailbox
    import dcmb_pkg::*;
#(
    parameter int unsigned DATA_W = DCMB_DATA_W
)
(
    input  wire logic              i_clk,               // 50 MHz clock.
    input  wire logic              i_rst_n,             // Async reset, low.
    input  wire dcmb_port_ctl_s    i_port_a_ctl,        // Port-A controls.
    input  wire dcmb_port_ctl_s    i_port_b_ctl,        // Port-B controls.
    input  wire logic [DATA_W-1:0] i_port_a_data_bus,   // Port-A bus in.
    input  wire logic [DATA_W-1:0] i_port_b_data_bus,   // Port-B bus in.
    input  wire logic [DATA_W-1:0] i_fifo_out_word,     // FIFO output reg.
    output logic      [DATA_W-1:0] o_port_a_data_bus,   // Port-A bus out.
    output logic                   o_port_a_data_oe,    // Port-A drive.
    output logic      [DATA_W-1:0] o_port_b_data_bus,   // Port-B bus out.
    output logic                   o_port_b_data_oe,    // Port-B drive.
    output logic                   o_a_to_b_full_n,     // A-to-B mail waits.
    output logic                   o_b_to_a_full_n      // B-to-A mail waits.
);

    // The mail words are held at the package width; refuse anything else.
    if (DATA_W != DCMB_DATA_W)
    begin : g_width_check
        $error("dcmb_mailbox: DATA_W must equal the mail word width.");
    end

    // Both ports share i_clk here, so the flags need no synchroniser; a
    // build with truly separate port clocks would have to add a two-stage
    // crossing on every flag and accept extra flag latency.
    // Mail state, one word and one full flag per direction.
    logic [DATA_W-1:0] a_to_b_mail_r;   // [RULE1]
    logic [DATA_W-1:0] b_to_a_mail_r;   // [RULE1]
    logic [DATA_W-1:0] a_to_b_mail_nxt;
    logic [DATA_W-1:0] b_to_a_mail_nxt;
    logic              a_to_b_full_n_r;
    logic              b_to_a_full_n_r;
    logic              a_to_b_full_n_nxt;
    logic              b_to_a_full_n_nxt;

    // Registered bus drive.
    logic [DATA_W-1:0] port_a_out_r;
    logic [DATA_W-1:0] port_b_out_r;
    logic [DATA_W-1:0] port_a_out_nxt;
    logic [DATA_W-1:0] port_b_out_nxt;
    logic              port_a_oe_r;
    logic              port_b_oe_r;

    dcmb_port_dec_s    dec_a;
    dcmb_port_dec_s    dec_b;
    wire logic         a_sel;
    wire logic         b_sel;
    wire logic         a_wr_ok;
    wire logic         b_wr_ok;

    // A port is addressed only with chip select low and enable high;
    // the mail select then steers between mail and FIFO paths.
    assign a_sel = !i_port_a_ctl.chip_select_n && i_port_a_ctl.enable
                   && i_port_a_ctl.mail_select;   // [RULE13] [RULE11]
    assign b_sel = !i_port_b_ctl.chip_select_n && i_port_b_ctl.enable
                   && i_port_b_ctl.mail_select;   // [RULE13] [RULE11]

    // Direction meaning differs per port: high writes on A, reads on B.
    assign dec_a.mail_write = a_sel
                && (i_port_a_ctl.direction == DCMB_A_DIR_WRITE);
    assign dec_a.mail_read  = a_sel
                && (i_port_a_ctl.direction != DCMB_A_DIR_WRITE);
    assign dec_a.out_active = !i_port_a_ctl.chip_select_n
                && (i_port_a_ctl.direction != DCMB_A_DIR_WRITE);
    assign dec_b.mail_write = b_sel
                && (i_port_b_ctl.direction != DCMB_B_DIR_READ);
    assign dec_b.mail_read  = b_sel
                && (i_port_b_ctl.direction == DCMB_B_DIR_READ);
    assign dec_b.out_active = !i_port_b_ctl.chip_select_n
                && (i_port_b_ctl.direction == DCMB_B_DIR_READ);

    // A write lands only while the flag is high, so unread mail is never
    // overwritten; a flag-low write is dropped without any indication.
    assign a_wr_ok = dec_a.mail_write && a_to_b_full_n_r;   // [RULE5]
    assign b_wr_ok = dec_b.mail_write && b_to_a_full_n_r;   // [RULE5]

    // Contents change only on accepted writes; reads leave them intact.
    assign a_to_b_mail_nxt = a_wr_ok ? i_port_a_data_bus
                                     : a_to_b_mail_r;   // [RULE2] [RULE10]
    assign b_to_a_mail_nxt = b_wr_ok ? i_port_b_data_bus
                                     : b_to_a_mail_r;   // [RULE3] [RULE10]

    // Write sets the flag low; the far-side read returns it high. The
    // write is tested first so a new word in the same cycle is not lost.
    assign a_to_b_full_n_nxt = a_wr_ok       ? 1'h0 :   // [RULE4]
                               dec_b.mail_read ? 1'h1 : // [RULE8]
                               a_to_b_full_n_r;
    assign b_to_a_full_n_nxt = b_wr_ok       ? 1'h0 :   // [RULE4]
                               dec_a.mail_read ? 1'h1 : // [RULE9]
                               b_to_a_full_n_r;

    // Bus data is launched from the updated word so a reader sees mail
    // written at the same edge; the cost is one cycle of output latency.
    assign port_a_out_nxt = b_to_a_mail_nxt;                       // [RULE7]
    assign port_b_out_nxt = i_port_b_ctl.mail_select
                          ? a_to_b_mail_nxt
                          : i_fifo_out_word;   // [RULE6]

    // Mail words and flags.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            a_to_b_mail_r   <= DCMB_MAIL_RST;
            b_to_a_mail_r   <= DCMB_MAIL_RST;
            a_to_b_full_n_r <= DCMB_FULL_N_RST;
            b_to_a_full_n_r <= DCMB_FULL_N_RST;
        end
        else
        begin
            a_to_b_mail_r   <= a_to_b_mail_nxt;
            b_to_a_mail_r   <= b_to_a_mail_nxt;
            a_to_b_full_n_r <= a_to_b_full_n_nxt;
            b_to_a_full_n_r <= b_to_a_full_n_nxt;
        end
    end

    // Output drivers and their enables.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            port_a_out_r <= DCMB_MAIL_RST;
            port_b_out_r <= DCMB_MAIL_RST;
            port_a_oe_r  <= 1'h0;
            port_b_oe_r  <= 1'h0;
        end
        else
        begin
            port_a_out_r <= port_a_out_nxt;
            port_b_out_r <= port_b_out_nxt;
            port_a_oe_r  <= dec_a.out_active;
            port_b_oe_r  <= dec_b.out_active;
        end
    end

    // Every output comes straight from a flip-flop.
    assign o_port_a_data_bus = port_a_out_r;
    assign o_port_a_data_oe  = port_a_oe_r;
    assign o_port_b_data_bus = port_b_out_r;
    assign o_port_b_data_oe  = port_b_oe_r;
    assign o_a_to_b_full_n   = a_to_b_full_n_r;
    assign o_b_to_a_full_n   = b_to_a_full_n_r;

    // Checks on the mail behaviour, all in the single clock domain.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // An accepted port-A write must land whole and mark the mail waiting.
    property p_ab_store;
        dec_a.mail_write && a_to_b_full_n_r
        |=> a_to_b_mail_r == $past(i_port_a_data_bus) && !a_to_b_full_n_r;
    endproperty
    a_ab_store: assert property (p_ab_store) // [RULE2]
        else $error("A-to-B write not stored.");

    // An accepted port-B write must land whole and mark the mail waiting.
    property p_ba_store;
        dec_b.mail_write && b_to_a_full_n_r
        |=> b_to_a_mail_r == $past(i_port_b_data_bus) && !b_to_a_full_n_r;
    endproperty
    a_ba_store: assert property (p_ba_store) // [RULE3]
        else $error("B-to-A write not stored.");

    // Each flag may only fall after a write to its own register; a
    // combined check would let one port's write excuse the other's flag.
    property p_flag_low_on_write;
        ($fell(a_to_b_full_n_r) |-> $past(a_wr_ok))
        and ($fell(b_to_a_full_n_r) |-> $past(b_wr_ok));
    endproperty
    a_flag_low_on_write: assert property (p_flag_low_on_write) // [RULE4]
        else $error("Full flag fell without a write.");

    // Waiting mail is frozen until the far side has read it.
    property p_write_ignored;
        !a_to_b_full_n_r |=> $stable(a_to_b_mail_r);
    endproperty
    a_write_ignored: assert property (p_write_ignored) // [RULE5] [RULE10]
        else $error("A-to-B mail changed while full.");

    // Same freeze for the mail travelling from port B to port A.
    property p_ba_write_ignored;
        !b_to_a_full_n_r |=> $stable(b_to_a_mail_r);
    endproperty
    a_ba_write_ignored: assert property (p_ba_write_ignored) // [RULE5]
        else $error("B-to-A mail changed while full.");

    // A refused write leaves the flag low unless a read frees it.
    property p_ab_write_blocked;
        dec_a.mail_write && !a_to_b_full_n_r && !dec_b.mail_read
        |=> !a_to_b_full_n_r;
    endproperty
    a_ab_write_blocked: assert property (p_ab_write_blocked) // [RULE5]
        else $error("Refused A-to-B write moved the flag.");

    // The port-B counterpart of the refused-write check.
    property p_ba_write_blocked;
        dec_b.mail_write && !b_to_a_full_n_r && !dec_a.mail_read
        |=> !b_to_a_full_n_r;
    endproperty
    a_ba_write_blocked: assert property (p_ba_write_blocked) // [RULE5]
        else $error("Refused B-to-A write moved the flag.");

    // A mail read on port B shows the A-to-B word one cycle later.
    property p_b_out_mux;
        dec_b.mail_read
        |=> o_port_b_data_oe && o_port_b_data_bus == a_to_b_mail_r;
    endproperty
    a_b_out_mux: assert property (p_b_out_mux) // [RULE6]
        else $error("Port-B bus not showing A-to-B mail.");

    // With the mail select low, port B carries the FIFO output word.
    property p_b_out_fifo;
        dec_b.out_active && !i_port_b_ctl.mail_select
        |=> o_port_b_data_oe && o_port_b_data_bus == $past(i_fifo_out_word);
    endproperty
    a_b_out_fifo: assert property (p_b_out_fifo) // [RULE6]
        else $error("Port-B bus not showing the FIFO word.");

    // Port A always shows the B-to-A word while it drives.
    property p_a_out_mail;
        dec_a.out_active ##1 !$past(b_wr_ok)
        |-> o_port_a_data_oe && o_port_a_data_bus == b_to_a_mail_r;
    endproperty
    a_a_out_mail: assert property (p_a_out_mail) // [RULE7]
        else $error("Port-A bus not showing B-to-A mail.");

    // Port-A drive follows chip select and read direction, one cycle late.
    property p_a_oe;
        (!i_port_a_ctl.chip_select_n
         && i_port_a_ctl.direction != DCMB_A_DIR_WRITE |=> o_port_a_data_oe)
        and (i_port_a_ctl.chip_select_n
             || i_port_a_ctl.direction == DCMB_A_DIR_WRITE
             |=> !o_port_a_data_oe);
    endproperty
    a_a_oe: assert property (p_a_oe) // [RULE7]
        else $error("Port-A drive enable wrong.");

    // Port-B drive follows chip select and read direction, one cycle late.
    property p_b_oe;
        (!i_port_b_ctl.chip_select_n
         && i_port_b_ctl.direction == DCMB_B_DIR_READ |=> o_port_b_data_oe)
        and (i_port_b_ctl.chip_select_n
             || i_port_b_ctl.direction != DCMB_B_DIR_READ
             |=> !o_port_b_data_oe);
    endproperty
    a_b_oe: assert property (p_b_oe) // [RULE6]
        else $error("Port-B drive enable wrong.");

    // A mail read on port B frees the A-to-B register unless a port-A write is accepted at the same edge.
    property p_ab_read_clears;
        dec_b.mail_read && !a_wr_ok |=> a_to_b_full_n_r;
    endproperty
    a_ab_read_clears: assert property (p_ab_read_clears) // [RULE8]
        else $error("A-to-B flag not returned high.");

    // A mail read on port A frees the B-to-A register unless a port-B write is accepted at the same edge.
    property p_ba_read_clears;
        dec_a.mail_read && !b_wr_ok |=> b_to_a_full_n_r;
    endproperty
    a_ba_read_clears: assert property (p_ba_read_clears) // [RULE9]
        else $error("B-to-A flag not returned high.");

    // A flag may only return high after a read from the far port.
    property p_ab_flag_rise;
        $rose(a_to_b_full_n_r) |-> $past(dec_b.mail_read);
    endproperty
    a_ab_flag_rise: assert property (p_ab_flag_rise) // [RULE8]
        else $error("A-to-B flag rose without a read.");

    // The B-to-A flag likewise needs a mail read on port A.
    property p_ba_flag_rise;
        $rose(b_to_a_full_n_r) |-> $past(dec_a.mail_read);
    endproperty
    a_ba_flag_rise: assert property (p_ba_flag_rise) // [RULE9]
        else $error("B-to-A flag rose without a read.");

    // Without a selected access nothing in the mail state may move.
    property p_idle_hold;
        !a_sel && !b_sel
        |=> $stable(a_to_b_full_n_r) && $stable(b_to_a_full_n_r)
            && $stable(a_to_b_mail_r) && $stable(b_to_a_mail_r);
    endproperty
    a_idle_hold: assert property (p_idle_hold) // [RULE13]
        else $error("Mail state moved without a selected access.");

    // A mail word moves only on its own accepted write, never the other's.
    property p_mail_separate;
        (!a_wr_ok |=> $stable(a_to_b_mail_r))
        and (!b_wr_ok |=> $stable(b_to_a_mail_r));
    endproperty
    a_mail_separate: assert property (p_mail_separate) // [RULE1] [RULE10]
        else $error("Mail word changed without its own write.");

    // Main scenarios: round trips, a refused write, a clash, a FIFO read.
    c_ab_round_trip: cover property (a_wr_ok ##[1:20] dec_b.mail_read);
    c_ba_round_trip: cover property (b_wr_ok ##[1:20] dec_a.mail_read);
    c_blocked_write: cover property (dec_a.mail_write && !a_to_b_full_n_r);
    c_write_and_read: cover property (a_wr_ok && dec_b.mail_read);
    c_fifo_read: cover property
        (dec_b.out_active && !i_port_b_ctl.mail_select);

endmodule

// File: tb/dcmb_host_model.sv
// Host-side model that resolves one port's two-way data bus.
`timescale 1ns/1ps
module dcmb_host_model
(
    input  wire logic        i_clk,  // Port clock.
    input  wire logic        i_oe,   // Device drives the bus.
    input  wire logic [35:0] i_dout, // Device bus value.
    output logic      [35:0] o_bus   // Level the host sees.
);
    logic [35:0] last_r;

    // Remember the last level so a released bus can drift away from it.
    always_ff @(posedge i_clk)
    begin
        last_r <= o_bus;
    end

    // A released bus flips to the inverse each cycle, so a stale copy passes only on every other cycle.
    assign o_bus = i_oe ? i_dout : ~last_r;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the mailbox pair.
`timescale 1ns/1ps
module tb_top;
    import dcmb_pkg::*;
    // Mail selects are used only in single-device mode.
    localparam dcmb_port_ctl_s IDLE = 4'h8;
    localparam dcmb_port_ctl_s A_WR = 4'h7;
    localparam dcmb_port_ctl_s A_RD = 4'h3;
    localparam dcmb_port_ctl_s B_RD = 4'h7;
    localparam dcmb_port_ctl_s B_WR = 4'h3;
    localparam dcmb_port_ctl_s B_FF = 4'h6;
    localparam dcmb_port_ctl_s B_OFF = 4'h1;
    localparam logic [35:0] W1 = 36'hA_5A5A_5A5A;
    localparam logic [35:0] W2 = 36'h5_A5A5_A5A5;
    localparam logic [35:0] W3 = 36'hC_3C3C_3C3C;
    localparam logic [35:0] FW = 36'h9_1234_5678;
    logic           i_clk = 1'h0;
    logic           i_rst_n = 1'h0;
    dcmb_port_ctl_s a_ctl = IDLE;
    dcmb_port_ctl_s b_ctl = IDLE;
    logic [35:0]    a_din = 36'h0;
    logic [35:0]    b_din = 36'h0;
    logic [35:0]    a_dout;
    logic [35:0]    b_dout;
    logic [35:0]    a_seen;
    logic [35:0]    b_seen;
    logic           a_oe;
    logic           b_oe;
    logic           ab_n;
    logic           ba_n;
    int             failures = 0;
    int             total_checks = 0;
    int             cyc = 0;

    dcmb_mailbox u_dcmb_mailbox (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_port_a_ctl(a_ctl), .i_port_b_ctl(b_ctl),
        .i_port_a_data_bus(a_din), .i_port_b_data_bus(b_din),
        .i_fifo_out_word(FW), .o_port_a_data_bus(a_dout),
        .o_port_a_data_oe(a_oe), .o_port_b_data_bus(b_dout),
        .o_port_b_data_oe(b_oe), .o_a_to_b_full_n(ab_n),
        .o_b_to_a_full_n(ba_n));
    dcmb_host_model u_dcmb_host_model_a (.i_clk(i_clk), .i_oe(a_oe),
        .i_dout(a_dout), .o_bus(a_seen));
    dcmb_host_model u_dcmb_host_model_b (.i_clk(i_clk), .i_oe(b_oe),
        .i_dout(b_dout), .o_bus(b_seen));

    // Free-running 50 MHz clock.
    initial
    begin
        forever #10 i_clk = ~i_clk;
    end

    task automatic chk(input string nm, input logic [35:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One access on each port; taken at the second edge, then idle again.
    task automatic acc(input dcmb_port_ctl_s a, b,
                       input logic [35:0] da, db);
        @(posedge i_clk);
        a_ctl <= a;
        b_ctl <= b;
        a_din <= da;
        b_din <= db;
        @(posedge i_clk);
        a_ctl <= IDLE;
        b_ctl <= IDLE;
        #1;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // A hang is cut short well past the expected run length.
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 400)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'h1;
        #1;
        chk("ab_full_n reset", {35'h0, ab_n}, 36'h1);
        chk("ba_full_n reset", {35'h0, ba_n}, 36'h1);
        // Mail A to B, a refused second write, then two reads.
        acc(A_WR, IDLE, W1, 36'h0);
        chk("ab_full_n write", {35'h0, ab_n}, 36'h0);
        acc(A_WR, IDLE, W2, 36'h0);
        chk("ab_full_n refused", {35'h0, ab_n}, 36'h0);
        acc(IDLE, B_RD, 36'h0, 36'h0);
        chk("b_oe read", {35'h0, b_oe}, 36'h1);
        chk("b_bus mail", b_seen, W1);
        chk("ab_full_n read", {35'h0, ab_n}, 36'h1);
        acc(IDLE, B_RD, 36'h0, 36'h0);
        chk("b_bus reread", b_seen, W1);
        acc(IDLE, B_FF, 36'h0, 36'h0);
        chk("b_bus fifo", b_seen, FW);
        $display("test a_to_b done");
        // Mail B to A, first with the port enable low.
        acc(IDLE, B_OFF, 36'h0, W3);
        chk("ba_full_n disabled", {35'h0, ba_n}, 36'h1);
        acc(IDLE, B_WR, 36'h0, W3);
        chk("ba_full_n write", {35'h0, ba_n}, 36'h0);
        acc(A_RD, IDLE, 36'h0, 36'h0);
        chk("a_bus mail", a_seen, W3);
        chk("a_oe read", {35'h0, a_oe}, 36'h1);
        chk("ba_full_n read", {35'h0, ba_n}, 36'h1);
        acc(A_RD, IDLE, 36'h0, 36'h0);
        chk("a_bus reread", a_seen, W3);
        $display("test b_to_a done");
        // Write on A and mail read on B at one edge: the write wins.
        acc(A_WR, B_RD, W2, 36'h0);
        chk("ab_full_n same edge", {35'h0, ab_n}, 36'h0);
        chk("b_bus same edge", b_seen, W2);
        $display("test same_edge done");
        end_sim();
    end
endmodule
